// file: ftc_codec.sv
// Purpose: decode and encode typed fields of byte-addressed management memory
// Assumes: inputs synchronous to mclk; bytes presented in address order
// Notes: decode paths are combinational, outputs are registered once
//
// Notes on behaviour
// - multi-byte numbers are big-endian, most significant byte lowest address.
// - a per-field flag selects little-endian storage instead.
// - a boolean is one bit, 1 true, 0 false, both ways.
// - compact float is mantissa times ten to exponent minus 24.
// - compact float byte 0 holds exponent and mantissa top, byte 1 rest.
// - signed types of 8, 16, 32, 64 bits are two's complement.
// - unsigned types take 1, 2, 4, 6 or 8 consecutive bytes.
// - sub-byte unsigned fields are extracted from a bit field of a byte.
// - a generic halfword decodes as float, signed or unsigned by selection.
// - an n-byte string is exactly n codes, no terminator.
// - set writes 1, clear writes 0, regardless of old value.
// - raise changes 0 to 1 only; cease changes 1 to 0 only.
`timescale 1ns/1ns
module ftc_codec
  import ftc_pkg::*;
#(
  parameter int STR_BYTES = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // numeric decode request
  input wire logic [FTC_MAX_BYTES*8-1:0] dec_bytes,
  input wire ftc_type_t dec_type,
  input wire logic dec_little,
  // numeric encode request
  input wire logic [63:0] enc_value,
  input wire ftc_type_t enc_type,
  input wire logic enc_little,
  // sub-byte field and boolean
  input wire logic [7:0] fld_byte,
  input wire logic [2:0] fld_lsb,
  input wire logic [2:0] fld_width,
  // bit update
  input wire logic bit_old,
  input wire ftc_op_t bit_op,
  // string pass
  input wire logic [STR_BYTES*8-1:0] str_bytes,
  // results
  output ftc_num_t dec_out,
  output logic [FTC_MAX_BYTES*8-1:0] enc_bytes,
  output logic [7:0] fld_value,
  output logic bool_value,
  output logic bit_new,
  output logic bit_changed,
  output logic [STR_BYTES*8-1:0] str_codes
);
  // refuse a string window that the output stage cannot hold
  if (STR_BYTES < 1) begin : gen_str_check
    $error("STR_BYTES must be at least one");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // bytes a type occupies
  function automatic int type_len(input ftc_type_t t);
    unique case (t)
      unsigned_byte_int, signed_byte_int: type_len = 1;
      unsigned_halfword_int, signed_halfword_int, compact_decimal_float: type_len = 2;
      unsigned_word_int, signed_word_int: type_len = 4;
      unsigned_six_byte_int: type_len = 6;
      default: type_len = 8;
    endcase
  endfunction

  // gather n bytes into a right-aligned number
  function automatic logic [63:0] pack_num(input logic [63:0] b, input int n,
                                           input logic little);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < FTC_MAX_BYTES; i++) begin
      if (i < n) begin
        if (little) begin
          r[i*8 +: 8] = b[i*8 +: 8];
        end else begin
          r[(n-1-i)*8 +: 8] = b[i*8 +: 8];
        end
      end
    end
    pack_num = r;
  endfunction

  // ---------------------------------------------------------------
  // combinational decode and encode
  // ---------------------------------------------------------------
  ftc_num_t next_dec_out;
  logic [63:0] next_enc_bytes;
  logic [7:0] next_fld_value;
  logic next_bool_value;
  logic next_bit_new;
  logic next_bit_changed;

  // numeric decode with sign extension
  always_comb begin
    logic [63:0] raw;
    int n;
    raw = 64'h0;
    n = type_len(dec_type);
    next_dec_out = '0;
    raw = pack_num(dec_bytes, n, dec_little);
    next_dec_out.value = raw;
    unique case (dec_type)
      signed_byte_int: next_dec_out.value = {{56{raw[7]}}, raw[7:0]};
      signed_halfword_int: next_dec_out.value = {{48{raw[15]}}, raw[15:0]};
      signed_word_int: next_dec_out.value = {{32{raw[31]}}, raw[31:0]};
      signed_dword_int: next_dec_out.value = raw;
      compact_decimal_float: begin
        next_dec_out.exponent = raw[15:11];
        next_dec_out.mantissa = raw[10:0];
      end
      default: next_dec_out.value = raw;
    endcase
    // unsigned and float values are never negative, whatever their top bit
    next_dec_out.negative = (dec_type inside {signed_byte_int, signed_halfword_int,
      signed_word_int, signed_dword_int}) && next_dec_out.value[63];
  end

  // numeric encode into address-ordered bytes
  always_comb begin
    logic [63:0] src;
    int n;
    n = type_len(enc_type);
    src = enc_value;
    if (enc_type == compact_decimal_float) begin
      // value low 11 bits mantissa, bits 15:11 exponent
      src = {48'h0, enc_value[15:11], enc_value[10:0]};
    end
    next_enc_bytes = pack_num(src, n, enc_little);
  end

  // sub-byte field, boolean and bit update
  always_comb begin
    logic [7:0] mask;
    mask = 8'(({1'b0, 8'hff} >> (4'h8 - {1'b0, fld_width})));
    next_fld_value = (fld_byte >> fld_lsb) & mask;
    next_bool_value = fld_byte[fld_lsb];
    unique case (bit_op)
      ftc_op_set: next_bit_new = 1'b1;
      ftc_op_clear: next_bit_new = 1'b0;
      ftc_op_raise: next_bit_new = 1'b1;
      ftc_op_cease: next_bit_new = 1'b0;
    endcase
    // raise and cease only count as a change from the opposite level
    next_bit_changed = (next_bit_new != bit_old);
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dec_out <= '0;
      enc_bytes <= '0;
      fld_value <= 8'h00;
      bool_value <= 1'b0;
      bit_new <= 1'b0;
      bit_changed <= 1'b0;
      str_codes <= '0;
    end else begin
      dec_out <= next_dec_out;
      enc_bytes <= next_enc_bytes;
      fld_value <= next_fld_value;
      bool_value <= next_bool_value;
      bit_new <= next_bit_new;
      bit_changed <= next_bit_changed;
      str_codes <= str_bytes;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  be_halfword_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == unsigned_halfword_int && !dec_little) |=>
      dec_out.value[15:0] == {$past(dec_bytes[7:0]), $past(dec_bytes[15:8])})
    else $error("big-endian halfword wrong");
  le_halfword_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == unsigned_halfword_int && dec_little) |=>
      dec_out.value[15:0] == $past(dec_bytes[15:0]))
    else $error("little-endian halfword wrong");
  bool_decode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 bool_value == $past(fld_byte[fld_lsb]))
    else $error("boolean decode wrong");
  float_fields_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == compact_decimal_float && !dec_little) |=>
      dec_out.exponent == $past(dec_bytes[7:3]) &&
      dec_out.mantissa == {$past(dec_bytes[2:0]), $past(dec_bytes[15:8])})
    else $error("compact float split wrong");
  signed_byte_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == signed_byte_int) |=>
      dec_out.negative == $past(dec_bytes[7]) && dec_out.value[7:0] == $past(dec_bytes[7:0]))
    else $error("signed byte wrong");
  six_byte_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == unsigned_six_byte_int) |=> dec_out.value[63:48] == 16'h0000)
    else $error("six byte value not zero-extended");
  subbyte_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (fld_width == 3'h3) |=> fld_value < 8'h08)
    else $error("sub-byte field out of range");
  set_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (bit_op == ftc_op_set || bit_op == ftc_op_clear) |=>
      bit_new == $past(bit_op == ftc_op_set))
    else $error("set or clear wrote the wrong value");
  raise_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (bit_op == ftc_op_raise && bit_old) |=> !bit_changed && bit_new)
    else $error("raise changed a one bit");
  signed_half_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == signed_halfword_int) |=>
      dec_out.value[63:16] == {48{dec_out.value[15]}})
    else $error("signed halfword not sign-extended");
  float_value_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == compact_decimal_float) |=>
      dec_out.value[63:16] == 48'h0 && !dec_out.negative)
    else $error("compact float carries a wider value");
  unsigned_sign_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dec_type == unsigned_dword_int) |=> !dec_out.negative)
    else $error("unsigned value flagged negative");
  cease_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (bit_op == ftc_op_cease && !bit_old) |=> !bit_changed && !bit_new)
    else $error("cease changed a zero bit");
  string_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 str_codes == $past(str_bytes))
    else $error("string codes altered");
endmodule

// file: ftc_pkg.sv
// Purpose: shared types and constants for the management field type codec
// Assumes: byte 0 of a field window is the byte at the lowest address
// Notes: widths and field positions of the compact float live here
package ftc_pkg;
  // ---------------------------------------------------------------
  // field windows and type selection
  // ---------------------------------------------------------------
  localparam int FTC_MAX_BYTES = 8;
  localparam int FTC_EXP_MSB = 7;
  localparam int FTC_EXP_LSB = 3;
  localparam int FTC_MAN_HI_MSB = 2;
  localparam int FTC_EXP_BIAS = 24;
  localparam logic [10:0] FTC_MAN_MAX = 11'h7ff;
  localparam logic [4:0] FTC_EXP_MAX = 5'h1f;

  // numeric field type; generic halfword uses the three 16-bit codes
  typedef enum logic [3:0] {
    unsigned_byte_int = 4'h0,
    unsigned_halfword_int = 4'h1,
    unsigned_word_int = 4'h2,
    unsigned_six_byte_int = 4'h3,
    unsigned_dword_int = 4'h4,
    signed_byte_int = 4'h5,
    signed_halfword_int = 4'h6,
    signed_word_int = 4'h7,
    signed_dword_int = 4'h8,
    compact_decimal_float = 4'h9
  } ftc_type_t;

  // bit update operations
  typedef enum logic [1:0] {
    ftc_op_set = 2'h0,
    ftc_op_clear = 2'h1,
    ftc_op_raise = 2'h2,
    ftc_op_cease = 2'h3
  } ftc_op_t;

  // decoded numeric value
  typedef struct packed {
    logic [63:0] value;
    logic [10:0] mantissa;
    logic [4:0] exponent;
    logic negative;
  } ftc_num_t;
endpackage

// file: ftc_codec_tb.sv
// Purpose: self-checking bench for the field type codec
// Assumes: outputs follow inputs of the previous mclk edge
// Notes: driver notes expectations in a queue, monitor checks them
`timescale 1ns/1ns
module ftc_codec_tb;
  import ftc_pkg::*;
  // ---------------------------------------------------------------
  // signals and expectation queue
  // ---------------------------------------------------------------
  localparam int SB = 4;
  typedef struct {
    ftc_num_t d;
    logic [63:0] e;
    logic [7:0] f;
    logic b;
    logic nb;
    logic ch;
    logic [SB*8-1:0] s;
    ftc_type_t t;
  } ftc_exp_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [63:0] dec_bytes = '0;
  ftc_type_t dec_type = unsigned_byte_int;
  logic dec_little = 1'b0;
  logic [63:0] enc_value = '0;
  ftc_type_t enc_type = unsigned_byte_int;
  logic enc_little = 1'b0;
  logic [7:0] fld_byte = '0;
  logic [2:0] fld_lsb = '0;
  logic [2:0] fld_width = 3'h1;
  logic bit_old = 1'b0;
  ftc_op_t bit_op = ftc_op_set;
  logic [SB*8-1:0] str_bytes = '0;
  ftc_num_t dec_out;
  logic [63:0] enc_bytes;
  logic [7:0] fld_value;
  logic bool_value;
  logic bit_new;
  logic bit_changed;
  logic [SB*8-1:0] str_codes;
  logic [31:0] seed = 32'h2ed792d1;
  int n_fail = 0;
  int compares = 0;
  int pend;
  ftc_exp_t q[$];
  ftc_exp_t x;

  ftc_codec #(.STR_BYTES(SB)) uut (.mclk(mclk), .reset_n(reset_n), .dec_bytes(dec_bytes),
    .dec_type(dec_type), .dec_little(dec_little), .enc_value(enc_value), .enc_type(enc_type),
    .enc_little(enc_little), .fld_byte(fld_byte), .fld_lsb(fld_lsb), .fld_width(fld_width),
    .bit_old(bit_old), .bit_op(bit_op), .str_bytes(str_bytes), .dec_out(dec_out),
    .enc_bytes(enc_bytes), .fld_value(fld_value), .bool_value(bool_value), .bit_new(bit_new),
    .bit_changed(bit_changed), .str_codes(str_codes));

  // clock at 8 ns
  initial begin
    forever #4 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // byte count of a numeric type
  function automatic int ftc_len(ftc_type_t t);
    case (t)
      unsigned_byte_int, signed_byte_int: return 1;
      unsigned_word_int, signed_word_int: return 4;
      unsigned_six_byte_int: return 6;
      unsigned_dword_int, signed_dword_int: return 8;
      default: return 2;
    endcase
  endfunction

  // note the expected results of the current inputs, then move on one cycle
  task automatic step();
    ftc_exp_t m;
    int n;
    logic sg;
    n = ftc_len(dec_type);
    sg = dec_type inside {signed_byte_int, signed_halfword_int, signed_word_int, signed_dword_int};
    m.d = '0;
    for (int i = 0; i < n; i++)
      m.d.value = dec_little ? m.d.value | (64'(dec_bytes[8*i+:8]) << 8*i)
                             : (m.d.value << 8) | 64'(dec_bytes[8*i+:8]);
    if (sg && m.d.value[8*n-1]) m.d.value = m.d.value | (~64'h0 << 8*n); // sign extension
    m.d.negative = sg & m.d.value[63];
    m.d.mantissa = m.d.value[10:0];
    m.d.exponent = m.d.value[15:11];
    m.e = '0;
    n = ftc_len(enc_type);
    for (int i = 0; i < n; i++)
      m.e[8*i+:8] = enc_little ? enc_value[8*i+:8] : enc_value[8*(n-1-i)+:8];
    m.f = (fld_byte >> fld_lsb) & ((8'h1 << fld_width) - 8'h1);
    m.b = fld_byte[fld_lsb];
    m.nb = bit_op == ftc_op_set || bit_op == ftc_op_raise;
    m.ch = m.nb != bit_old;
    m.s = str_bytes;
    m.t = dec_type;
    q.push_back(m);
    @(posedge mclk);
    #1;
  endtask

  // random inputs within the accepted ranges
  task automatic rand_in();
    dec_bytes = {rnd(), rnd()};
    dec_type = ftc_type_t'(rnd() % 10);
    dec_little = dec_type != compact_decimal_float && rnd() % 2 == 0;
    enc_value = {rnd(), rnd()};
    enc_type = ftc_type_t'(rnd() % 10);
    enc_little = enc_type != compact_decimal_float && rnd() % 2 == 0;
    fld_byte = 8'(rnd());
    fld_width = 3'(1 + rnd() % 7);
    fld_lsb = 3'(rnd() % (9 - fld_width));
    bit_old = 1'(rnd() % 2);
    bit_op = ftc_op_t'(rnd() % 4);
    str_bytes = rnd();
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: one note per result, oldest first
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    pend = q.size();
    #2;
    if (pend > 0) begin
      x = q.pop_front();
      chk(dec_out.value === x.d.value, "decoded value");
      if (x.t == compact_decimal_float)
        chk({dec_out.exponent, dec_out.mantissa} === {x.d.exponent, x.d.mantissa}, "float");
      chk(dec_out.negative === x.d.negative, "sign flag");
      chk(enc_bytes === x.e, "encoded bytes");
      chk(fld_value === x.f, "sub-byte field");
      chk(bool_value === x.b, "boolean");
      chk(bit_new === x.nb, "bit update");
      chk(bit_changed === x.ch, "bit change");
      chk(str_codes === x.s, "string codes");
    end
  end

  // main sequence: reset, directed cases, then random back-to-back traffic
  initial begin
    repeat (4) @(posedge mclk);
    #2;
    chk(dec_out === '0 && enc_bytes === '0 && bit_new === 1'b0, "reset outputs");
    chk(fld_value === 8'h00 && bool_value === 1'b0 && bit_changed === 1'b0, "reset flags");
    chk(str_codes === '0, "reset string");
    @(posedge mclk);
    #1;
    reset_n = 1'b1;
    dec_bytes = 64'h3412;
    dec_type = unsigned_halfword_int;
    step();
    dec_bytes = 64'hffff;
    dec_type = compact_decimal_float;
    step();
    for (int t = 0; t < 20; t++) begin
      rand_in();
      dec_type = ftc_type_t'(t / 2);
      enc_type = ftc_type_t'(t / 2);
      dec_little = t % 2 == 1 && t < 18;
      enc_little = dec_little;
      dec_bytes[7] = 1'b1;
      step();
    end
    for (int o = 0; o < 8; o++) begin
      rand_in();
      bit_op = ftc_op_t'(o / 2);
      bit_old = 1'(o % 2);
      step();
    end
    repeat (300) begin
      rand_in();
      step();
    end
    for (int i = 0; i < 5 && q.size() > 0; i++) @(posedge mclk);
    #3;
    if (q.size() > 0) chk(1'b0, "results missing");
    give_verdict();
  end
endmodule
